// [core/ald_core.sv]
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - File forms use working register 0 implicitly.
// - Squares only W4 to W7 times itself.
// - Multiplies only ordered pairs among W4-W7.
// - Sixteen working registers, any as source/destination.
// - X prefetch via W8/W9, steps, W9+W12.
// - Y prefetch via W10/W11, steps, W11+W12.
// - Prefetched data lands only in W4-W7.
// - Scaled signed word into accumulator, DSP flags.
// - Add with carry adds carry, full flags.
// - Carry, digit carry, sign, overflow, sticky zero flags.
// - Overflow and saturation flags per accumulator.
module ald_core #(
	parameter int NUM_W = ald_pkg::NW
) (
	input  wire logic                       clk_sys, // Core clock.
	input  wire logic                       srst,    // Synchronous reset, active high.
	input  wire logic                       psel,    // APB select.
	input  wire logic                       penable, // APB access phase.
	input  wire logic                       pwrite,  // APB direction, high writes.
	input  wire logic [ald_pkg::ADDR_W-1:0] paddr,   // APB byte address.
	input  wire logic [ald_pkg::BUS_W-1:0]  pwdata,  // APB write data.
	output logic      [ald_pkg::BUS_W-1:0]  prdata,  // APB read data.
	output logic                            pready,  // APB ready.
	output logic                            pslverr  // APB error on unmapped address.
);
	import ald_pkg::*;

	logic [DW-1:0]    w_q [NUM_W];
	logic [DW-1:0]    w_d [NUM_W];
	logic [DW-1:0]    file_q, file_d, xdata_q, xdata_d, ydata_q, ydata_d;
	logic [DW-1:0]    xea_q, xea_d, yea_q, yea_d;
	logic [AW-1:0]    acca_q, acca_d, accb_q, accb_d;
	ald_flags_s       flg_q, flg_d;
	logic [BUS_W-1:0] prdata_q, prdata_d;
	logic             pready_q, pready_d, pslverr_q, pslverr_d;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic         acc_ph, wr_fire, cmd_fire, w_hit, mapped;
	logic [3:0]   w_idx;
	ald_alu_cmd_s ac;
	ald_mac_cmd_s mc;

	assign acc_ph   = psel && penable;
	assign wr_fire  = acc_ph && pready_q && pwrite;
	assign cmd_fire = wr_fire && (paddr == OFF_CMD);
	assign w_hit    = (paddr[7:6] == W_PAGE) && (paddr[1:0] == 2'h0);
	assign w_idx    = paddr[5:2];
	assign ac       = ald_alu_cmd_s'(pwdata);
	assign mc       = ald_mac_cmd_s'(pwdata);

	always_comb begin
		case (paddr)
			OFF_CMD, OFF_STATUS, OFF_FILE, OFF_XDATA, OFF_YDATA, OFF_XADDR, OFF_YADDR,
			OFF_ACCA_L, OFF_ACCA_H, OFF_ACCB_L, OFF_ACCB_H: mapped = 1'b1;
			default: mapped = w_hit;
		endcase
	end

	// ----------------------------------------------------------------
	// Word ALU
	// ----------------------------------------------------------------
	logic          is_add, is_cadd, is_and, is_alu, dst_file, cin;
	logic [DW-1:0] op_a, op_b, res;
	logic [3:0]    dst_w;
	logic [DW:0]   sum;
	logic [NIB:0]  nib;

	assign is_add  = ac.op inside {[OP_ADD_F:OP_ADD_WL5]};
	assign is_cadd = ac.op inside {[OP_CADD_F:OP_CADD_WL5]};
	assign is_and  = ac.op inside {[OP_AND_F:OP_AND_WL5]};
	assign is_alu  = is_add || is_cadd || is_and;

	always_comb begin
		op_a     = '0;
		op_b     = '0;
		dst_w    = W_DEF;
		dst_file = 1'b0;
		case (ac.op)
			OP_ADD_F, OP_CADD_F, OP_AND_F: begin
				op_a     = file_q;
				op_b     = w_q[W_DEF];
				dst_file = 1'b1;
			end
			OP_ADD_FW, OP_CADD_FW, OP_AND_FW: begin
				op_a = file_q;
				op_b = w_q[W_DEF];
			end
			OP_ADD_LIT, OP_CADD_LIT, OP_AND_LIT: begin
				op_a  = DW'(ac.lit);
				op_b  = w_q[ac.wd];
				dst_w = ac.wd;
			end
			OP_ADD_WWW, OP_CADD_WWW, OP_AND_WWW: begin
				op_a  = w_q[ac.wb];
				op_b  = w_q[ac.ws];
				dst_w = ac.wd;
			end
			OP_ADD_WL5, OP_CADD_WL5, OP_AND_WL5: begin
				op_a  = w_q[ac.wb];
				op_b  = DW'(ac.lit[ULIT_W-1:0]);
				dst_w = ac.wd;
			end
			default: ;
		endcase
	end

	assign cin = is_cadd && flg_q.c;
	assign sum = {1'b0, op_a} + {1'b0, op_b} + (DW+1)'(cin);
	assign nib = {1'b0, op_a[NIB-1:0]} + {1'b0, op_b[NIB-1:0]} + (NIB+1)'(cin);
	assign res = is_and ? (op_a & op_b) : sum[DW-1:0];

	// ----------------------------------------------------------------
	// Accumulator path and DSP operand checks
	// ----------------------------------------------------------------
	logic               acc_dst, sat_ev, sq_ok, mul_ok, x_ok, y_ok, mac_ok;
	logic signed [AW-1:0] sac_opd, sac_val, acc_a_in, acc_b_in, acc_sum;
	logic signed [SLIT_W-1:0] slit;
	logic [SLIT_W-1:0]  sh_mag;
	logic signed [2*DW-1:0] prod;
	logic [DW-1:0]      src_w;
	logic [3:0]         xb, yb;

	assign acc_dst = ac.acc;
	assign src_w   = w_q[ac.ws];
	// The word lands on the accumulator's sign-aligned fraction, guard bits sign-extended.
	assign sac_opd = {{(AW-DW-ACC_ALIGN){src_w[DW-1]}}, src_w, {ACC_ALIGN{1'b0}}};
	assign slit    = ac.lit[SLIT_W-1:0];
	assign sh_mag  = slit[SLIT_W-1] ? SLIT_W'(-slit) : SLIT_W'(slit);
	// A positive literal shifts right, a negative one left.
	assign sac_val = slit[SLIT_W-1] ? (sac_opd <<< sh_mag) : (sac_opd >>> sh_mag);
	assign prod    = $signed(w_q[mc.wm]) * $signed(w_q[mc.wn]);

	assign sq_ok  = (mc.wm == mc.wn) && (mc.wm >= W_MUL_LO) && (mc.wm <= W_MUL_HI);
	assign mul_ok = (mc.wm < mc.wn) && (mc.wm >= W_MUL_LO) && (mc.wn <= W_MUL_HI);
	assign x_ok   = (mc.xmode <= PF_DEC6) || ((mc.xmode == PF_IDX) && mc.xreg);
	assign y_ok   = (mc.ymode <= PF_DEC6) || ((mc.ymode == PF_IDX) && mc.yreg);
	assign mac_ok = (sq_ok || mul_ok) && x_ok && y_ok;
	assign xb     = mc.xreg ? W_X1 : W_X0;
	assign yb     = mc.yreg ? W_Y1 : W_Y0;

	always_comb begin
		case (ac.op)
			OP_ADD_ACC: begin
				acc_a_in = acca_q;
				acc_b_in = accb_q;
			end
			OP_SAC_ADD: begin
				acc_a_in = acc_dst ? accb_q : acca_q;
				acc_b_in = sac_val;
			end
			default: begin
				acc_a_in = acc_dst ? accb_q : acca_q;
				acc_b_in = AW'(prod);
			end
		endcase
	end

	assign acc_sum = acc_a_in + acc_b_in;
	// Saturation marks a wrap beyond the guard bits, which no later result can undo.
	assign sat_ev  = (acc_a_in[AW-1] == acc_b_in[AW-1]) && (acc_sum[AW-1] != acc_a_in[AW-1]);

	function automatic logic acc_ovf(input logic [AW-1:0] v);
		return (|v[AW-1:ACC_SIGN]) && !(&v[AW-1:ACC_SIGN]);
	endfunction : acc_ovf

	function automatic logic [DW-1:0] pf_step(input logic [3:0] mode);
		case (mode)
			PF_INC2: pf_step = STEP2;
			PF_INC4: pf_step = STEP4;
			PF_INC6: pf_step = STEP6;
			PF_DEC2: pf_step = -STEP2;
			PF_DEC4: pf_step = -STEP4;
			PF_DEC6: pf_step = -STEP6;
			default: pf_step = '0;
		endcase
	endfunction : pf_step

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		w_d     = w_q;
		file_d  = file_q;
		xdata_d = xdata_q;
		ydata_d = ydata_q;
		xea_d   = xea_q;
		yea_d   = yea_q;
		acca_d  = acca_q;
		accb_d  = accb_q;
		flg_d   = flg_q;
		if (wr_fire) begin
			if (w_hit) begin
				w_d[w_idx] = pwdata[DW-1:0];
			end
			case (paddr)
				OFF_STATUS: flg_d = ald_flags_s'(pwdata[FLAG_W-1:0]);
				OFF_FILE:   file_d = pwdata[DW-1:0];
				OFF_XDATA:  xdata_d = pwdata[DW-1:0];
				OFF_YDATA:  ydata_d = pwdata[DW-1:0];
				OFF_ACCA_L: acca_d[ACC_LO_W-1:0] = pwdata;
				OFF_ACCA_H: acca_d[AW-1:ACC_LO_W] = pwdata[AW-ACC_LO_W-1:0];
				OFF_ACCB_L: accb_d[ACC_LO_W-1:0] = pwdata;
				OFF_ACCB_H: accb_d[AW-1:ACC_LO_W] = pwdata[AW-ACC_LO_W-1:0];
				OFF_CMD: begin
					if (is_alu) begin
						if (dst_file) begin
							file_d = res;
						end else begin
							w_d[dst_w] = res;
						end
						flg_d.n = res[DW-1];
						// Carry chains keep zero sticky so a multiword sum tests zero overall.
						flg_d.z = is_cadd ? (flg_q.z && (res == '0)) : (res == '0);
						if (!is_and) begin
							flg_d.c  = sum[DW];
							flg_d.digit_carry_flag = nib[NIB];
							flg_d.ov = (op_a[DW-1] == op_b[DW-1]) && (res[DW-1] != op_a[DW-1]);
						end
					end else if ((ac.op == OP_ADD_ACC) || (ac.op == OP_SAC_ADD)
						|| ((ac.op == OP_MAC) && mac_ok)) begin
						if (ac.op == OP_MAC) begin
							if (mc.ymode != PF_NONE) begin
								yea_d = w_q[yb] + ((mc.ymode == PF_IDX) ? w_q[W_OFS] : '0);
								w_d[yb] = w_q[yb] + pf_step(mc.ymode);
								w_d[W_MUL_LO + 4'(mc.yd)] = ydata_q;
							end
							// X is written last so it wins when both prefetches name one register.
							if (mc.xmode != PF_NONE) begin
								xea_d = w_q[xb] + ((mc.xmode == PF_IDX) ? w_q[W_OFS] : '0);
								w_d[xb] = w_q[xb] + pf_step(mc.xmode);
								w_d[W_MUL_LO + 4'(mc.xd)] = xdata_q;
							end
						end
						if (acc_dst) begin
							accb_d = acc_sum;
							flg_d.acc_b_saturate_flag = flg_q.acc_b_saturate_flag
								|| sat_ev;
						end else begin
							acca_d = acc_sum;
							flg_d.acc_a_saturate_flag = flg_q.acc_a_saturate_flag
								|| sat_ev;
						end
						flg_d.acc_a_overflow_flag = acc_ovf(acca_d);
						flg_d.acc_b_overflow_flag = acc_ovf(accb_d);
					end else if (ac.op == OP_MAC) begin
						flg_d.ill = 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		pready_d  = acc_ph && !pready_q;
		pslverr_d = acc_ph && !pready_q && !mapped;
		prdata_d  = '0;
		if (acc_ph && !pready_q && !pwrite) begin
			case (paddr)
				OFF_STATUS: prdata_d = BUS_W'(flg_q);
				OFF_FILE:   prdata_d = BUS_W'(file_q);
				OFF_XDATA:  prdata_d = BUS_W'(xdata_q);
				OFF_YDATA:  prdata_d = BUS_W'(ydata_q);
				OFF_XADDR:  prdata_d = BUS_W'(xea_q);
				OFF_YADDR:  prdata_d = BUS_W'(yea_q);
				OFF_ACCA_L: prdata_d = acca_q[ACC_LO_W-1:0];
				OFF_ACCA_H: prdata_d = BUS_W'(acca_q[AW-1:ACC_LO_W]);
				OFF_ACCB_L: prdata_d = accb_q[ACC_LO_W-1:0];
				OFF_ACCB_H: prdata_d = BUS_W'(accb_q[AW-1:ACC_LO_W]);
				default:    prdata_d = w_hit ? BUS_W'(w_q[w_idx]) : '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_W; i++) begin : g_wfile
		always_ff @(posedge clk_sys) begin
			if (srst) begin
				w_q[i] <= '0;
			end else begin
				w_q[i] <= w_d[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			file_q    <= '0;
			xdata_q   <= '0;
			ydata_q   <= '0;
			xea_q     <= '0;
			yea_q     <= '0;
			acca_q    <= '0;
			accb_q    <= '0;
			flg_q     <= '0;
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			file_q    <= file_d;
			xdata_q   <= xdata_d;
			ydata_q   <= ydata_d;
			xea_q     <= xea_d;
			yea_q     <= yea_d;
			acca_q    <= acca_d;
			accb_q    <= accb_d;
			flg_q     <= flg_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_w0_default: assert property (
		cmd_fire && (ac.op == OP_ADD_FW) |=> w_q[W_DEF] == $past(res))
		else $error("File form did not write working register 0.");
	a_square_pair: assert property (
		cmd_fire && (ac.op == OP_MAC) && (mc.wm == mc.wn)
		&& ((mc.wm < W_MUL_LO) || (mc.wm > W_MUL_HI))
		|=> flg_q.ill && $stable(acca_q) && $stable(accb_q))
		else $error("Illegal square pair was accepted.");
	a_mul_order: assert property (
		cmd_fire && (ac.op == OP_MAC) && (mc.wm > mc.wn) |=> flg_q.ill)
		else $error("Reversed multiply pair was accepted.");
	a_reg_write: assert property (
		wr_fire && w_hit |=> w_q[$past(w_idx)] == $past(pwdata[DW-1:0]))
		else $error("Working register write lost.");
	a_x_step: assert property (
		cmd_fire && (ac.op == OP_MAC) && mac_ok && (mc.xmode == PF_INC6)
		|=> w_q[$past(xb)] == $past(w_q[xb]) + STEP6)
		else $error("X address post-increment wrong.");
	a_y_index: assert property (
		cmd_fire && (ac.op == OP_MAC) && (mc.ymode == PF_IDX) && !mc.yreg |=> flg_q.ill)
		else $error("Indexed Y prefetch on wrong register accepted.");
	a_x_dest: assert property (
		cmd_fire && (ac.op == OP_MAC) && mac_ok && (mc.xmode != PF_NONE)
		|=> w_q[W_MUL_LO + 4'($past(mc.xd))] == $past(xdata_q))
		else $error("X prefetch data not in its destination.");
	a_sac_flags: assert property (
		cmd_fire && (ac.op == OP_SAC_ADD) |=> $stable(flg_q.c) && $stable(flg_q.z)
		&& $stable(flg_q.ov) && $stable(flg_q.n) && $stable(flg_q.digit_carry_flag))
		else $error("Accumulator add touched core flags.");
	a_cadd_sum: assert property (
		cmd_fire && (ac.op == OP_CADD_WWW)
		|=> w_q[$past(ac.wd)] == $past(DW'(w_q[ac.wb] + w_q[ac.ws] + DW'(flg_q.c))))
		else $error("Add with carry result wrong.");
	a_and_flags: assert property (
		cmd_fire && is_and |=> $stable(flg_q.c) && $stable(flg_q.digit_carry_flag)
		&& $stable(flg_q.ov))
		else $error("AND changed arithmetic flags.");
	a_acc_sum: assert property (
		cmd_fire && (ac.op == OP_ADD_ACC) && !ac.acc
		|=> (acca_q == $past(AW'(acca_q + accb_q)))
		&& (flg_q.acc_a_overflow_flag == acc_ovf(acca_q)))
		else $error("Accumulator sum or overflow flag wrong.");
	a_sticky_zero: assert property (
		cmd_fire && is_cadd && !flg_q.z |=> !flg_q.z)
		else $error("Sticky zero set after nonzero carry chain.");
	a_sat_sticky: assert property (
		flg_q.acc_b_saturate_flag && !(wr_fire && (paddr == OFF_STATUS))
		|=> flg_q.acc_b_saturate_flag)
		else $error("Saturation flag of B dropped on its own.");

	c_mac_ok: cover property (cmd_fire && (ac.op == OP_MAC) && mac_ok && (mc.xmode == PF_IDX));
	c_cadd_cin: cover property (cmd_fire && is_cadd && flg_q.c);
	c_sac_left: cover property (cmd_fire && (ac.op == OP_SAC_ADD) && slit[SLIT_W-1]);

endmodule : ald_core

// [core/ald_pkg.sv]
package ald_pkg;

	localparam int DW        = 16;
	localparam int AW        = 40;
	localparam int NW        = 16;
	localparam int ADDR_W    = 8;
	localparam int BUS_W     = 32;
	localparam int NIB       = 4;
	localparam int ULIT_W    = 5;
	localparam int SLIT_W    = 4;
	localparam int ACC_ALIGN = 16;
	localparam int ACC_SIGN  = 31;
	localparam int ACC_LO_W  = 32;
	localparam int FLAG_W    = 10;

	// Register byte offsets; working register n is word n of the page W_PAGE.
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_FILE   = 8'h08;
	localparam logic [7:0] OFF_XDATA  = 8'h0c;
	localparam logic [7:0] OFF_YDATA  = 8'h10;
	localparam logic [7:0] OFF_XADDR  = 8'h14;
	localparam logic [7:0] OFF_YADDR  = 8'h18;
	localparam logic [7:0] OFF_ACCA_L = 8'h20;
	localparam logic [7:0] OFF_ACCA_H = 8'h24;
	localparam logic [7:0] OFF_ACCB_L = 8'h28;
	localparam logic [7:0] OFF_ACCB_H = 8'h2c;
	localparam logic [1:0] W_PAGE     = 2'h1;

	localparam logic [3:0] W_DEF    = 4'h0;
	localparam logic [3:0] W_MUL_LO = 4'h4;
	localparam logic [3:0] W_MUL_HI = 4'h7;
	localparam logic [3:0] W_X0     = 4'h8;
	localparam logic [3:0] W_X1     = 4'h9;
	localparam logic [3:0] W_Y0     = 4'ha;
	localparam logic [3:0] W_Y1     = 4'hb;
	localparam logic [3:0] W_OFS    = 4'hc;

	localparam logic [3:0] PF_NONE  = 4'h0;
	localparam logic [3:0] PF_PLAIN = 4'h1;
	localparam logic [3:0] PF_INC2  = 4'h2;
	localparam logic [3:0] PF_INC4  = 4'h3;
	localparam logic [3:0] PF_INC6  = 4'h4;
	localparam logic [3:0] PF_DEC2  = 4'h5;
	localparam logic [3:0] PF_DEC4  = 4'h6;
	localparam logic [3:0] PF_DEC6  = 4'h7;
	localparam logic [3:0] PF_IDX   = 4'h8;

	localparam logic [15:0] STEP2 = 16'h0002;
	localparam logic [15:0] STEP4 = 16'h0004;
	localparam logic [15:0] STEP6 = 16'h0006;

	typedef enum logic [4:0] {
		OP_NOP      = 5'h00,
		OP_ADD_F    = 5'h01, OP_ADD_FW   = 5'h02, OP_ADD_LIT  = 5'h03,
		OP_ADD_WWW  = 5'h04, OP_ADD_WL5  = 5'h05,
		OP_CADD_F   = 5'h06, OP_CADD_FW  = 5'h07, OP_CADD_LIT = 5'h08,
		OP_CADD_WWW = 5'h09, OP_CADD_WL5 = 5'h0a,
		OP_AND_F    = 5'h0b, OP_AND_FW   = 5'h0c, OP_AND_LIT  = 5'h0d,
		OP_AND_WWW  = 5'h0e, OP_AND_WL5  = 5'h0f,
		OP_ADD_ACC  = 5'h10, OP_SAC_ADD  = 5'h11, OP_MAC      = 5'h12
	} ald_op_e;

	typedef struct packed {
		logic [3:0]  rsvd;
		logic        acc;
		logic [9:0]  lit;
		logic [3:0]  wd;
		logic [3:0]  ws;
		logic [3:0]  wb;
		ald_op_e     op;
	} ald_alu_cmd_s;

	typedef struct packed {
		logic [3:0]  rsvd;
		logic        acc;
		logic [1:0]  yd;
		logic [1:0]  xd;
		logic        yreg;
		logic        xreg;
		logic [3:0]  ymode;
		logic [3:0]  xmode;
		logic [3:0]  wn;
		logic [3:0]  wm;
		ald_op_e     op;
	} ald_mac_cmd_s;

	typedef struct packed {
		logic ill;
		logic acc_b_saturate_flag;
		logic acc_a_saturate_flag;
		logic acc_b_overflow_flag;
		logic acc_a_overflow_flag;
		logic z;
		logic ov;
		logic n;
		logic digit_carry_flag;
		logic c;
	} ald_flags_s;

endpackage : ald_pkg

// [dv/ald_tb.sv]
`timescale 1ns/100ps
module testbench;
	import ald_pkg::*;

	logic                   clk_sys;
	logic                   srst;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [ADDR_W-1:0]      paddr;
	logic [BUS_W-1:0]       pwdata;
	logic [BUS_W-1:0]       prdata;
	logic                   pready;
	logic                   pslverr;
	int                     mismatches;
	int                     checks;
	int                     cycles;

	ald_core ald_core_inst (
		.clk_sys (clk_sys),
		.srst    (srst),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	always #50 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------
	// Verdict and hang guard
	// ----------------------------------------------------------------
	task automatic give_verdict();
		if (mismatches == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// The whole run needs well under two thousand cycles.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Bus access and comparison
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Reads pready and data in the active region of the edge, so they are the sampled values.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic er);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// A slave that never answers is ended by the cycle guard, which counts it.
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, rd, er);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 32'h0, rd, er);
		chk(nm, exp, rd);
	endtask : rdc

	function automatic logic [7:0] wa(input logic [3:0] n);
		return {W_PAGE, n, 2'b00};
	endfunction : wa

	function automatic logic [31:0] alu(input ald_op_e op, input logic [3:0] wb,
			input logic [3:0] ws, input logic [9:0] lit, input logic acc);
		return {4'h0, acc, lit, 4'h3, ws, wb, op};
	endfunction : alu

	function automatic logic [31:0] mac(input logic [3:0] wm, input logic [3:0] wn,
			input logic [3:0] xm, input logic [3:0] ym, input logic xr, input logic yr,
			input logic [1:0] xd, input logic [1:0] yd);
		return {4'h0, 1'b0, yd, xd, yr, xr, ym, xm, wn, wm, OP_MAC};
	endfunction : mac

	// Operands: FILE=a, W0=b, W1=a, W2=b, W3=b; the result lands in FILE, W0 or W3.
	task automatic op_run(input ald_op_e op, input logic [9:0] pre, input logic [15:0] a,
			input logic [15:0] b, input logic [9:0] lit, input logic [15:0] res,
			input logic [9:0] st);
		logic [7:0] ra;
		ra = (op == OP_ADD_F || op == OP_CADD_F || op == OP_AND_F) ? OFF_FILE :
			(op == OP_ADD_FW || op == OP_CADD_FW || op == OP_AND_FW) ? wa(4'h0) : wa(4'h3);
		wr(OFF_STATUS, {22'h0, pre});
		wr(OFF_FILE, {16'h0, a});
		wr(wa(4'h0), {16'h0, b});
		wr(wa(4'h1), {16'h0, a});
		wr(wa(4'h2), {16'h0, b});
		wr(wa(4'h3), {16'h0, b});
		wr(OFF_CMD, alu(op, 4'h1, 4'h2, lit, 1'b0));
		rdc(ra, {16'h0, res}, "result");
		rdc(OFF_STATUS, {22'h0, st}, "status");
	endtask : op_run

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic        er;
		logic [15:0] step [8];
		clk_sys = 1'b0;
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		checks = 0;
		cycles = 0;
		step = '{16'h0, 16'h0, 16'h2, 16'h4, 16'h6, 16'hfffe, 16'hfffc, 16'hfffa};
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rdc(OFF_STATUS, 32'h0, "status reset");
		apb(1'b0, 8'h30, 32'h0, rd, er);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		for (int i = 0; i < 16; i++) wr(wa(i[3:0]), 32'h0000a500 + i);
		for (int i = 0; i < 16; i++) rdc(wa(i[3:0]), 32'h0000a500 + i, "wfile");
		op_run(OP_ADD_F, 10'h00, 16'h0005, 16'h0003, 10'h000, 16'h0008, 10'h000);
		op_run(OP_ADD_FW, 10'h00, 16'h0008, 16'h0008, 10'h000, 16'h0010, 10'h002);
		op_run(OP_ADD_LIT, 10'h00, 16'h0000, 16'h0001, 10'h3ff, 16'h0400, 10'h002);
		op_run(OP_ADD_WWW, 10'h00, 16'h7fff, 16'h0001, 10'h000, 16'h8000, 10'h00e);
		op_run(OP_ADD_WWW, 10'h01, 16'hffff, 16'h0001, 10'h000, 16'h0000, 10'h013);
		op_run(OP_ADD_WL5, 10'h00, 16'h0001, 16'h0000, 10'h01f, 16'h0020, 10'h002);
		op_run(OP_CADD_F, 10'h01, 16'h0005, 16'h0003, 10'h000, 16'h0009, 10'h000);
		op_run(OP_CADD_FW, 10'h11, 16'hffff, 16'h0000, 10'h000, 16'h0000, 10'h013);
		op_run(OP_CADD_LIT, 10'h01, 16'h0000, 16'h0001, 10'h3ff, 16'h0401, 10'h002);
		op_run(OP_CADD_WWW, 10'h11, 16'h0001, 16'h0001, 10'h000, 16'h0003, 10'h000);
		op_run(OP_CADD_WWW, 10'h01, 16'hffff, 16'h0000, 10'h000, 16'h0000, 10'h003);
		op_run(OP_CADD_WL5, 10'h01, 16'h7fff, 16'h0000, 10'h000, 16'h8000, 10'h00e);
		op_run(OP_AND_F, 10'h0b, 16'h8f0f, 16'hf0f0, 10'h000, 16'h8000, 10'h00f);
		op_run(OP_AND_FW, 10'h0f, 16'h00ff, 16'hff00, 10'h000, 16'h0000, 10'h01b);
		op_run(OP_AND_LIT, 10'h00, 16'h0000, 16'h8201, 10'h3ff, 16'h0201, 10'h000);
		op_run(OP_AND_WWW, 10'h1f, 16'h0001, 16'h0001, 10'h000, 16'h0001, 10'h00b);
		op_run(OP_AND_WL5, 10'h00, 16'hffff, 16'h0000, 10'h010, 16'h0010, 10'h000);
		wr(OFF_ACCA_L, 32'h40000000);
		wr(OFF_ACCB_L, 32'h40000000);
		wr(OFF_STATUS, 32'h1);
		wr(OFF_CMD, alu(OP_ADD_ACC, 4'h0, 4'h0, 10'h0, 1'b0));
		rdc(OFF_ACCA_L, 32'h80000000, "acca lo");
		rdc(OFF_STATUS, 32'h21, "status acc a");
		wr(OFF_ACCB_L, 32'hffffffff);
		wr(OFF_ACCB_H, 32'h7f);
		wr(OFF_ACCA_L, 32'h1);
		wr(OFF_STATUS, 32'h0);
		wr(OFF_CMD, alu(OP_ADD_ACC, 4'h0, 4'h0, 10'h0, 1'b1));
		rdc(OFF_ACCB_H, 32'h80, "accb hi");
		rdc(OFF_STATUS, 32'h140, "status acc b");
		wr(OFF_CMD, alu(OP_ADD_ACC, 4'h0, 4'h0, 10'h0, 1'b1));
		rdc(OFF_STATUS, 32'h140, "sticky saturate");
		wr(OFF_ACCA_L, 32'h0);
		wr(OFF_STATUS, 32'h0);
		wr(wa(4'h1), 32'hfffe);
		wr(OFF_CMD, alu(OP_SAC_ADD, 4'h0, 4'h1, 10'h001, 1'b0));
		rdc(OFF_ACCA_L, 32'hffff0000, "sac lo");
		rdc(OFF_ACCA_H, 32'hff, "sac hi");
		wr(OFF_ACCB_L, 32'h0);
		wr(OFF_ACCB_H, 32'h0);
		wr(wa(4'h1), 32'h1);
		wr(OFF_CMD, alu(OP_SAC_ADD, 4'h0, 4'h1, 10'h00c, 1'b1));
		rdc(OFF_ACCB_L, 32'h00100000, "sac left");
		rdc(OFF_STATUS, 32'h0, "sac status");
		wr(OFF_ACCA_L, 32'h0);
		wr(OFF_ACCA_H, 32'h0);
		wr(wa(4'h4), 32'h3);
		wr(wa(4'h5), 32'hfffe);
		wr(wa(4'h8), 32'h0100);
		wr(wa(4'hb), 32'h0200);
		wr(wa(4'hc), 32'h0010);
		wr(OFF_XDATA, 32'h1234);
		wr(OFF_YDATA, 32'h5678);
		wr(OFF_CMD, mac(4'h4, 4'h5, PF_INC2, PF_IDX, 1'b0, 1'b1, 2'h2, 2'h3));
		rdc(OFF_ACCA_L, 32'hfffffffa, "mac product");
		rdc(wa(4'h6), 32'h1234, "x dest");
		rdc(wa(4'h7), 32'h5678, "y dest");
		rdc(wa(4'h8), 32'h0102, "x step");
		rdc(OFF_XADDR, 32'h0100, "x addr");
		rdc(OFF_YADDR, 32'h0210, "y indexed");
		rdc(wa(4'hb), 32'h0200, "y index kept");
		for (int m = 4; m < 8; m++) begin
			for (int n = 4; n < 8; n++) begin
				wr(OFF_STATUS, 32'h0);
				wr(OFF_CMD, mac(m[3:0], n[3:0], PF_NONE, PF_NONE, 1'b0, 1'b0, 2'h0, 2'h0));
				rdc(OFF_STATUS, (m > n) ? 32'h200 : 32'h0, "pair");
			end
		end
		wr(OFF_STATUS, 32'h0);
		wr(OFF_CMD, mac(4'h3, 4'h3, PF_NONE, PF_NONE, 1'b0, 1'b0, 2'h0, 2'h0));
		rdc(OFF_STATUS, 32'h200, "square low");
		wr(OFF_STATUS, 32'h0);
		wr(OFF_CMD, mac(4'h4, 4'h4, PF_IDX, PF_IDX, 1'b0, 1'b0, 2'h0, 2'h0));
		rdc(OFF_STATUS, 32'h200, "index base");
		for (int m = 1; m < 8; m++) begin
			wr(wa(4'h9), 32'h0100);
			wr(wa(4'ha), 32'h0300);
			wr(OFF_CMD, mac(4'h4, 4'h4, m[3:0], m[3:0], 1'b1, 1'b0, 2'h0, 2'h1));
			rdc(wa(4'h9), {16'h0, 16'h0100 + step[m]}, "x mode");
			rdc(wa(4'ha), {16'h0, 16'h0300 + step[m]}, "y mode");
			rdc(OFF_YADDR, 32'h0300, "y addr");
		end
		wr(OFF_STATUS, 32'h0);
		wr(OFF_CMD, mac(4'h4, 4'h4, PF_IDX, PF_NONE, 1'b1, 1'b0, 2'h0, 2'h0));
		rdc(OFF_XADDR, 32'h010a, "x indexed");
		rdc(wa(4'h9), 32'h00fa, "x index kept");
		rdc(OFF_STATUS, 32'h0, "x index legal");
		give_verdict();
	end
endmodule : testbench
